// >>> core/vsu_core.sv
// Behaviour
// - RAM word n: low byte at base+2n, high byte at base+2n+1.
// - Host reaches any byte, word, double word, any alignment, no wait, while no list runs.
// - Element n: base clears wrap-1 bits; offset steps modulo 2^wrap.
// - Accumulator is two 34-bit halves, 68 bits complex.
// - Integer and real reads use real half; extended uses imaginary.
// - Non-complex loads write the same value into both halves.
// - Round flag goes to bit 14 first; storing truncates.
// - Clear flag 0 keeps accumulator; 1 clears and seeds bit 14.
// - Rounding only for real, aligned-real and complex types.
// - Product with real part added first, imaginary part afterwards.
// - Reserved command stops list, raises NMI, sets undefined flag.
// - Opcodes 2, 3, 4 load first, second, third pointer.
// - Opcode 5 puts real and imaginary words in bits 30..15.
// - Complex load sets bit 14 to the round flag.
// - Extended load reads first vector element 0, bits 31..1 to 30..0.
// - Command is 5-bit opcode over 11-bit argument.
// - Any end of list drops running flag and sets halt status.
`timescale 1ns/1ps
`default_nettype none
`include "vsu_map.svh"
module vsu_core
  import vsu_pkg::*;
#(
  parameter int          RAM_BYTES   = `VSU_RAM_BYTES,
  parameter int          RAM_AW      = `VSU_RAM_AW,
  parameter logic [31:0] DEFINED_OPS = `VSU_DEFINED_OPS
) (
  // Clock and reset
  input  wire logic          CLK,
  input  wire logic          RST_B,
  // Host memory port
  input  wire vsu_host_req_t HOST_REQ,
  output logic      [31:0]   HOST_RDATA,
  // List control and status
  input  wire logic          LIST_START,
  input  wire logic [15:0]   LIST_START_ADDR,
  input  wire logic          LIST_ABORT,
  input  wire logic          HALT_CLR,
  input  wire logic          FLAG_CLR,
  output logic               LIST_RUNNING_FLAG,
  output logic               HALT_IRQ_STATUS,
  output logic               UNDEFINED_CMD_FLAG,
  output logic               ACCESS_ERR_FLAG,
  output logic               NMI_REQ,
  // Parameter bits
  input  wire logic          ROUND_FLAG,
  input  wire logic          ACC_CLEAR_FLAG,
  // Accumulate datapath
  input  wire vsu_mac_t      MAC_REQ,
  output vsu_acc_t           ACC,
  output logic      [33:0]   ACC_REAL_READ,
  output logic      [31:0]   ACC_EXT_READ,
  output vsu_cplx_t          ACC_STORE,
  // Vector pointers
  output vsu_ptr_t           FIRST_PTR,
  output vsu_ptr_t           SECOND_PTR,
  output vsu_ptr_t           THIRD_PTR,
  output logic      [15:0]   FIRST_ELEM0_ADDR
);

  typedef struct packed {
    vsu_state_t  state;
    logic [15:0] cl_ptr;
    logic [15:0] cmd;
    vsu_ptr_t    ptr_x;
    vsu_ptr_t    ptr_y;
    vsu_ptr_t    ptr_z;
    vsu_acc_t    acc;
    vsu_acc_t    mac_pend;
    logic        mac_second;
    logic        host_rd_q;
    logic        running;
    logic        halt_st;
    logic        und;
    logic        err;
    logic        nmi;
  } vsu_st_t;

  vsu_st_t st;
  vsu_st_t next_st;

  logic              ram_rd;
  logic              ram_wr;
  logic [RAM_AW-1:0] ram_addr;
  logic [3:0]        ram_be;
  logic [31:0]       ram_rdata;
  logic [31:0]       host_off;
  logic              host_hit;
  logic              host_acc;
  logic [4:0]        op;
  logic [10:0]       arg;
  logic              is_ptr_ld;
  logic              is_acc_ld;
  logic              is_ext_ld;
  logic              trap;
  logic              stop;
  logic              seed_bit;
  vsu_acc_t          base_acc;

  // Cyclic-buffer element address, word units
  function automatic logic [15:0] elem_addr(vsu_ptr_t p,
                                            logic [15:0] n);
    logic [4:0]  wm1;
    logic [16:0] clr_mask;
    logic [16:0] wrap_mask;
    logic [16:0] sum;
    wm1       = (p.wrap == 5'h00) ? 5'h00 : p.wrap - 5'h01;
    clr_mask  = (17'h00001 << wm1) - 17'h00001;
    wrap_mask = (17'h00001 << p.wrap) - 17'h00001;
    sum       = {1'b0, p.addr} + ({1'b0, n} << p.step);
    elem_addr = p.addr & ~clr_mask[15:0];
    elem_addr = elem_addr + (sum[15:0] & wrap_mask[15:0]);
  endfunction

  // Split a loaded double word into pointer fields
  function automatic vsu_ptr_t split_ptr(logic [31:0] d);
    split_ptr.addr = d[`VSU_PTR_ADDR_MSB:`VSU_PTR_ADDR_LSB];
    split_ptr.step = d[`VSU_PTR_STEP_MSB:`VSU_PTR_STEP_LSB];
    split_ptr.wrap = d[`VSU_PTR_WRAP_MSB:`VSU_PTR_WRAP_LSB];
  endfunction

  // Word to 34-bit half with round bit below it
  function automatic logic [33:0] word_half(logic [15:0] w, logic r);
    word_half = {{3{w[15]}}, w, r, 14'h0000};
  endfunction

  // Round-capable data types
  function automatic logic rounds(vsu_dtype_t t);
    rounds = (t == DT_REAL) || (t == DT_AREAL) ||
             (t == DT_COMPLEX);
  endfunction

  vsu_ram #(
    .BYTES (RAM_BYTES),
    .AW    (RAM_AW)
  ) u_ram (
    .clk   (CLK),
    .rd    (ram_rd),
    .wr    (ram_wr),
    .addr  (ram_addr),
    .be    (ram_be),
    .wdata (HOST_REQ.wdata),
    .rdata (ram_rdata)
  );

  // Host window decode
  assign host_off = HOST_REQ.addr - `VSU_RAM_BASE;
  assign host_hit = host_off < 32'(RAM_BYTES);
  assign host_acc = host_hit && (HOST_REQ.rd || HOST_REQ.wr);

  // Command fields
  assign op  = ram_rdata[`VSU_OP_MSB:`VSU_OP_LSB];
  assign arg = ram_rdata[`VSU_ARG_MSB:`VSU_ARG_LSB];
  assign is_ptr_ld = (op == `VSU_OP_LOAD_X) || (op == `VSU_OP_LOAD_Y) ||
                     (op == `VSU_OP_LOAD_Z);
  assign is_acc_ld = op == `VSU_OP_LOAD_ACC;
  assign is_ext_ld = (op == `VSU_OP_EXEC) && (arg == `VSU_ARG_LOAD_EXT);
  assign trap = (st.state == ST_FETCH) && !DEFINED_OPS[op];

  // Seed for accumulate start
  assign seed_bit = ROUND_FLAG && rounds(MAC_REQ.dtype);
  always_comb
  begin
    if (ACC_CLEAR_FLAG)
    begin
      base_acc.re = 34'(seed_bit) << `VSU_ROUND_BIT;
      base_acc.im = 34'(seed_bit) << `VSU_ROUND_BIT;
    end
    else
    begin
      base_acc = st.acc;
    end
  end

  always_comb
  begin
    next_st = st;
    next_st.nmi = 1'b0;
    next_st.host_rd_q = 1'b0;
    ram_rd = 1'b0;
    ram_wr = 1'b0;
    ram_addr = '0;
    ram_be = 4'h0;
    stop = 1'b0;

    // Status clears; later sets win
    if (HALT_CLR)
      next_st.halt_st = 1'b0;
    if (FLAG_CLR)
    begin
      next_st.und = 1'b0;
      next_st.err = 1'b0;
    end

    // Host access: free while idle, refused while running
    if (host_acc && !st.running)
    begin
      ram_addr = host_off[RAM_AW-1:0];
      ram_rd = HOST_REQ.rd;
      ram_wr = HOST_REQ.wr;
      next_st.host_rd_q = HOST_REQ.rd;
      unique case (HOST_REQ.size)
        `VSU_SIZE_BYTE: ram_be = 4'h1;
        `VSU_SIZE_WORD: ram_be = 4'h3;
        default:        ram_be = 4'hF;
      endcase
    end
    else if (host_acc)
    begin
      next_st.err = 1'b1;
      next_st.nmi = 1'b1;
      stop = 1'b1;
    end

    // Accumulate: real-part term, then imaginary-part term
    if (st.mac_second)
    begin
      next_st.acc.re = st.acc.re + st.mac_pend.re;
      next_st.acc.im = st.acc.im + st.mac_pend.im;
      next_st.mac_second = 1'b0;
    end
    else if (MAC_REQ.valid)
    begin
      next_st.acc.re = base_acc.re + MAC_REQ.term_re.re;
      next_st.acc.im = base_acc.im + MAC_REQ.term_re.im;
      next_st.mac_pend = MAC_REQ.term_im;
      next_st.mac_second = 1'b1;
    end

    unique case (st.state)
      ST_IDLE:
      begin
        if (LIST_START)
        begin
          next_st.running = 1'b1;
          next_st.cl_ptr = LIST_START_ADDR;
          next_st.state = ST_ISSUE;
        end
      end
      ST_ISSUE:
      begin
        if (!stop)
        begin
          ram_rd = 1'b1;
          ram_be = 4'h3;
          ram_addr = RAM_AW'({st.cl_ptr, 1'b0});
        end
        next_st.state = ST_FETCH;
      end
      ST_FETCH:
      begin
        next_st.cmd = ram_rdata[15:0];
        if (trap)
        begin
          next_st.und = 1'b1;
          next_st.nmi = 1'b1;
          stop = 1'b1;
        end
        else if (op == `VSU_OP_HALT)
        begin
          stop = 1'b1;
        end
        else if (is_ptr_ld || is_acc_ld)
        begin
          ram_rd = !stop;
          ram_be = 4'hF;
          ram_addr = RAM_AW'({arg, 1'b0});
          next_st.state = ST_LOAD;
        end
        else if (is_ext_ld)
        begin
          ram_rd = !stop;
          ram_be = 4'hF;
          ram_addr = RAM_AW'({elem_addr(st.ptr_x, 16'h0000),
                              1'b0});
          next_st.state = ST_LOAD;
        end
        else
        begin
          next_st.cl_ptr = st.cl_ptr + 16'h0001;
          next_st.state = ST_ISSUE;
        end
      end
      ST_LOAD:
      begin
        unique case (st.cmd[`VSU_OP_MSB:`VSU_OP_LSB])
          `VSU_OP_LOAD_X: next_st.ptr_x = split_ptr(ram_rdata);
          `VSU_OP_LOAD_Y: next_st.ptr_y = split_ptr(ram_rdata);
          `VSU_OP_LOAD_Z: next_st.ptr_z = split_ptr(ram_rdata);
          `VSU_OP_LOAD_ACC:
          begin
            next_st.acc.re = word_half(ram_rdata[15:0],
                                       ROUND_FLAG);
            next_st.acc.im = word_half(ram_rdata[31:16],
                                       ROUND_FLAG);
            next_st.mac_second = 1'b0;
          end
          default:
          begin
            next_st.acc.re = {{3{ram_rdata[31]}}, ram_rdata[31:1]};
            next_st.acc.im = {{3{ram_rdata[31]}}, ram_rdata[31:1]};
            next_st.mac_second = 1'b0;
          end
        endcase
        next_st.cl_ptr = st.cl_ptr + 16'h0001;
        next_st.state = ST_ISSUE;
      end
    endcase

    // Any end of the list
    if ((stop || LIST_ABORT) && st.running)
    begin
      next_st.running = 1'b0;
      next_st.halt_st = 1'b1;
      next_st.state = ST_IDLE;
    end
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      st <= '0;
      st.state <= ST_IDLE;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Outputs
  assign HOST_RDATA = st.host_rd_q ? ram_rdata : 32'h0000_0000;
  assign LIST_RUNNING_FLAG = st.running;
  assign HALT_IRQ_STATUS = st.halt_st;
  assign UNDEFINED_CMD_FLAG = st.und;
  assign ACCESS_ERR_FLAG = st.err;
  assign NMI_REQ = st.nmi;
  assign ACC = st.acc;
  assign ACC_REAL_READ = st.acc.re;
  assign ACC_EXT_READ = {st.acc.im[30:0], 1'b0};
  assign ACC_STORE.re = st.acc.re[`VSU_WORD_MSB:`VSU_WORD_LSB];
  assign ACC_STORE.im = st.acc.im[`VSU_WORD_MSB:`VSU_WORD_LSB];
  assign FIRST_PTR = st.ptr_x;
  assign SECOND_PTR = st.ptr_y;
  assign THIRD_PTR = st.ptr_z;
  assign FIRST_ELEM0_ADDR = elem_addr(st.ptr_x, 16'h0000);

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  AST_HALT_ON_END: assert property (
    $fell(st.running) |-> st.halt_st)
    else $error("List ended without halt status");

  AST_TRAP: assert property (
    trap && st.running |=> !st.running && st.und && st.nmi)
    else $error("Reserved command not trapped");

  AST_LA_FORMAT: assert property (
    st.state == ST_LOAD && st.cmd[15:11] == `VSU_OP_LOAD_ACC &&
    !LIST_ABORT && !host_acc
    |=> st.acc.re[30:15] == $past(ram_rdata[15:0]) &&
        st.acc.im[30:15] == $past(ram_rdata[31:16]) &&
        st.acc.re[14] == $past(ROUND_FLAG) &&
        st.acc.im[14] == $past(ROUND_FLAG))
    else $error("Complex load misplaced");

  AST_LEA_BOTH: assert property (
    st.state == ST_LOAD && st.cmd[15:11] == `VSU_OP_EXEC
    |=> st.acc.re == st.acc.im &&
        st.acc.im[30:0] == $past(ram_rdata[31:1]))
    else $error("Extended load not in both halves");

  AST_PTR_KEEPS_ACC: assert property (
    st.state == ST_LOAD && st.cmd[15:11] inside {5'h02, 5'h03, 5'h04} &&
    !MAC_REQ.valid && !st.mac_second |=> $stable(st.acc))
    else $error("Pointer load touched accumulator");

  AST_HOST_MAP: assert property (
    host_acc && !st.running && HOST_REQ.wr
    |-> ram_wr && ram_addr == host_off[RAM_AW-1:0])
    else $error("Host write not mapped");

  AST_BUSY_REFUSE: assert property (
    host_acc && st.running |-> !ram_wr ##1 st.err && !st.running)
    else $error("Host access while running not refused");

  AST_MAC_ORDER: assert property (
    MAC_REQ.valid && !st.mac_second && st.state != ST_LOAD
    ##1 st.state != ST_LOAD
    |-> st.acc.re == $past(base_acc.re) + $past(MAC_REQ.term_re.re)
        ##1 st.acc.re == $past(st.acc.re) + $past(st.mac_pend.re))
    else $error("Accumulate order wrong");

  AST_NO_ROUND_INT: assert property (
    MAC_REQ.valid && !st.mac_second && ACC_CLEAR_FLAG &&
    !rounds(MAC_REQ.dtype) && st.state != ST_LOAD
    |=> st.acc.re == $past(MAC_REQ.term_re.re))
    else $error("Rounding seeded for integer type");

endmodule
`default_nettype wire

// >>> core/vsu_map.svh
`ifndef VSU_MAP_SVH
`define VSU_MAP_SVH

// Host view of the shared RAM
`define VSU_RAM_BASE      32'hFFFE_0000
`define VSU_RAM_BYTES     4096
`define VSU_RAM_AW        12

// Command word fields
`define VSU_OP_MSB        15
`define VSU_OP_LSB        11
`define VSU_ARG_MSB       10
`define VSU_ARG_LSB       0

// Opcodes handled here
`define VSU_OP_LOAD_X     5'h02
`define VSU_OP_LOAD_Y     5'h03
`define VSU_OP_LOAD_Z     5'h04
`define VSU_OP_LOAD_ACC   5'h05
`define VSU_OP_EXEC       5'h10
`define VSU_OP_HALT       5'h19
`define VSU_ARG_LOAD_EXT  11'h533

// One bit per opcode: 1 = defined command, 0 = reserved
`define VSU_DEFINED_OPS   32'h3601_7EFD

// Vector pointer fields inside the loaded double word
`define VSU_PTR_ADDR_MSB  15
`define VSU_PTR_ADDR_LSB  0
`define VSU_PTR_STEP_MSB  19
`define VSU_PTR_STEP_LSB  16
`define VSU_PTR_WRAP_MSB  24
`define VSU_PTR_WRAP_LSB  20

// Accumulator layout
`define VSU_ROUND_BIT     14
`define VSU_WORD_LSB      15
`define VSU_WORD_MSB      30

// Host access sizes
`define VSU_SIZE_BYTE     2'h0
`define VSU_SIZE_WORD     2'h1
`define VSU_SIZE_DWORD    2'h2

`endif

// >>> core/vsu_pkg.sv
package vsu_pkg;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_ISSUE = 4'b0010,
    ST_FETCH = 4'b0100,
    ST_LOAD  = 4'b1000
  } vsu_state_t;

  typedef enum logic [2:0] {
    DT_INT     = 3'h0,
    DT_AINT    = 3'h1,
    DT_REAL    = 3'h2,
    DT_AREAL   = 3'h3,
    DT_EXT     = 3'h4,
    DT_COMPLEX = 3'h5
  } vsu_dtype_t;

  typedef struct packed {
    logic [4:0]  wrap;
    logic [3:0]  step;
    logic [15:0] addr;
  } vsu_ptr_t;

  typedef struct packed {
    logic [33:0] re;
    logic [33:0] im;
  } vsu_acc_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [1:0]  size;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } vsu_host_req_t;

  typedef struct packed {
    logic       valid;
    vsu_dtype_t dtype;
    vsu_acc_t   term_re;
    vsu_acc_t   term_im;
  } vsu_mac_t;

  typedef struct packed {
    logic [15:0] re;
    logic [15:0] im;
  } vsu_cplx_t;

endpackage

// >>> core/vsu_ram.sv
`timescale 1ns/1ps
`default_nettype none
module vsu_ram #(
  parameter int BYTES = 4096,
  parameter int AW    = 12
) (
  // Clock
  input  wire logic          clk,
  // Access port
  input  wire logic          rd,
  input  wire logic          wr,
  input  wire logic [AW-1:0] addr,
  input  wire logic [3:0]    be,
  input  wire logic [31:0]   wdata,
  output logic      [31:0]   rdata
);

  logic [7:0]    mem       [BYTES];
  logic [AW-1:0] lane_addr [4];

  // Byte address of each lane, wrapping at the top
  for (genvar k = 0; k < 4; k++)
  begin : g_lane
    assign lane_addr[k] = addr + AW'(k);
  end

  // One process owns the array: lane addresses vary at run time
  always_ff @(posedge clk)
  begin
    for (int k = 0; k < 4; k++)
    begin
      if (wr && be[k])
        mem[lane_addr[k]] <= wdata[8*k +: 8];
      if (rd)
        rdata[8*k +: 8] <= mem[lane_addr[k]];
    end
  end

endmodule
`default_nettype wire

// >>> verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "vsu_map.svh"
module tb
  import vsu_pkg::*;
;
  localparam logic [31:0] BASE = `VSU_RAM_BASE;
  localparam logic [1:0]  SZB  = `VSU_SIZE_BYTE;
  localparam logic [1:0]  SZW  = `VSU_SIZE_WORD;
  localparam logic [1:0]  SZD  = `VSU_SIZE_DWORD;
  localparam logic [31:0] XV   = 32'hC000_0003;

  logic          clk;
  logic          rst_b;
  vsu_host_req_t host_req;
  logic [31:0]   host_rdata;
  logic          list_start;
  logic [15:0]   list_start_addr;
  logic          list_abort;
  logic          halt_clr;
  logic          flag_clr;
  logic          running;
  logic          halt_st;
  logic          und;
  logic          acc_err;
  logic          nmi;
  logic          round;
  logic          acc_clr;
  vsu_mac_t      mac;
  vsu_acc_t      acc;
  vsu_acc_t      acc_exp;
  logic [33:0]   real_rd;
  logic [31:0]   ext_rd;
  vsu_cplx_t     store;
  vsu_ptr_t      ptr1;
  vsu_ptr_t      ptr2;
  vsu_ptr_t      ptr3;
  logic [15:0]   elem0;
  int            err_count;
  int            num_checks;

  vsu_core uut (
    .CLK(clk), .RST_B(rst_b), .HOST_REQ(host_req), .HOST_RDATA(host_rdata),
    .LIST_START(list_start), .LIST_START_ADDR(list_start_addr),
    .LIST_ABORT(list_abort), .HALT_CLR(halt_clr), .FLAG_CLR(flag_clr),
    .LIST_RUNNING_FLAG(running), .HALT_IRQ_STATUS(halt_st),
    .UNDEFINED_CMD_FLAG(und), .ACCESS_ERR_FLAG(acc_err), .NMI_REQ(nmi),
    .ROUND_FLAG(round), .ACC_CLEAR_FLAG(acc_clr), .MAC_REQ(mac),
    .ACC(acc), .ACC_REAL_READ(real_rd), .ACC_EXT_READ(ext_rd),
    .ACC_STORE(store), .FIRST_PTR(ptr1), .SECOND_PTR(ptr2),
    .THIRD_PTR(ptr3), .FIRST_ELEM0_ADDR(elem0)
  );

  vsu_host_model host (
    .CLK(clk), .HOST_REQ(host_req), .HOST_RDATA(host_rdata)
  );

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic test_done;
    if (err_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [67:0] seen, input logic [67:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [33:0] ext_half(input logic [31:0] v);
    return {{3{v[31]}}, v[31:1]};
  endfunction

  function automatic logic [33:0] cx_half(input logic [15:0] w,
                                          input logic r);
    return {{3{w[15]}}, w, r, 14'h0};
  endfunction

  function automatic vsu_acc_t add(input vsu_acc_t a, input vsu_acc_t b);
    return '{re: a.re + b.re, im: a.im + b.im};
  endfunction

  task automatic wr(input logic [31:0] off, input logic [1:0] sz,
                    input logic [31:0] d);
    logic [31:0] x;
    host.access(BASE + off, sz, d, 1'b1, x);
  endtask

  task automatic rd(input logic [31:0] a, input logic [1:0] sz,
                    output logic [31:0] d);
    host.access(a, sz, 32'h0, 1'b0, d);
  endtask

  task automatic start(input logic [15:0] a);
    @(posedge clk);
    halt_clr <= 1'b1;
    flag_clr <= 1'b1;
    list_start_addr <= a;
    @(posedge clk);
    halt_clr <= 1'b0;
    flag_clr <= 1'b0;
    list_start <= 1'b1;
    #1 chk({halt_st, und, acc_err}, 3'b000);
    @(posedge clk);
    list_start <= 1'b0;
    #1 chk(running, 1'b1);
  endtask

  task automatic wait_end(output int n);
    n = (nmi === 1'b1);
    repeat (40)
    begin
      if (running !== 1'b1)
        break;
      @(posedge clk);
      #1 n += (nmi === 1'b1);
    end
    @(posedge clk);
    #1 n += (nmi === 1'b1);
  endtask

  task automatic t_map;
    logic [31:0] d;
    chk(acc, '0);
    chk({halt_st, und, acc_err, nmi, running}, '0);
    wr(32'h0, SZD, 32'h4433_2211);
    wr(32'h4, SZB, 32'h55);
    rd(BASE + 1, SZB, d);
    chk(d[7:0], 8'h22);
    rd(BASE + 1, SZW, d);
    chk(d[15:0], 16'h3322);
    rd(BASE + 1, SZD, d);
    chk(d, 32'h5544_3322);
    rd(BASE + 2, SZW, d);
    chk(d[15:0], 16'h4433);
    rd(BASE - 4, SZD, d);
    chk(d, 32'h0);
  endtask

  // Lists read no value they write, operands on even words
  task automatic t_prog;
    wr(32'h20, SZD, 32'h1842_1040);
    wr(32'h24, SZD, 32'h8533_2044);
    wr(32'h28, SZW, 32'hC800);
    wr(32'h40, SZD, 32'h1040_2846);
    wr(32'h44, SZW, 32'hC800);
    wr(32'h50, SZW, 32'h0800);
    for (int i = 0; i < 8; i++)
      wr(32'h60 + 2 * i, SZW, 32'hD000);
    wr(32'h70, SZW, 32'hC800);
    wr(32'h80, SZD, 32'h0041_012A);
    wr(32'h84, SZD, 32'h00A2_0300);
    wr(32'h88, SZD, 32'h01F3_FFFE);
    wr(32'h8C, SZD, 32'h1234_8001);
    wr(32'h264, SZD, XV);
  endtask

  task automatic t_load;
    int n;
    start(16'h0010);
    wait_end(n);
    chk({running, halt_st}, 2'b01);
    chk(n, 0);
    chk(ptr1, 25'h041012A);
    chk(ptr2, 25'h0A20300);
    chk(ptr3, 25'h1F3FFFE);
    chk(elem0, 16'h0132);
    chk(acc, {2{ext_half(XV)}});
    chk(real_rd, ext_half(XV));
    chk(ext_rd, {XV[31:1], 1'b0});
  endtask

  // Accumulator is loaded here before the first accumulate only
  task automatic t_la(input logic r);
    int n;
    @(posedge clk);
    round <= r;
    start(16'h0020);
    wait_end(n);
    acc_exp = {cx_half(16'h8001, r), cx_half(16'h1234, r)};
    chk(acc, acc_exp);
    chk(store, 32'h8001_1234);
  endtask

  task automatic t_mac(input vsu_dtype_t dt, input logic clr);
    vsu_acc_t t1;
    vsu_acc_t t2;
    vsu_acc_t e;
    t1 = '{re: 34'h1_0000_0000, im: 34'h0_0000_8000};
    t2 = '{re: 34'h0_0000_0100, im: 34'h3_FFFF_FFFF};
    e = '0;
    if (!clr)
      e = acc_exp;
    else if (dt inside {DT_REAL, DT_AREAL, DT_COMPLEX})
      e = '{re: 34'h4000, im: 34'h4000};
    @(posedge clk);
    mac <= '{valid: 1'b1, dtype: dt, term_re: t1, term_im: t2};
    acc_clr <= clr;
    @(posedge clk);
    mac.valid <= 1'b0;
    #1 chk(acc, add(e, t1));
    @(posedge clk);
    #1 chk(acc, add(add(e, t1), t2));
    acc_exp = add(add(e, t1), t2);
  endtask

  // Mode 0 abort, 1 host access while running, 2 reserved command
  task automatic t_stop(input int mode, input logic [15:0] a);
    logic [31:0] d;
    int n;
    start(a);
    if (mode == 0)
    begin
      @(posedge clk);
      list_abort <= 1'b1;
      @(posedge clk);
      list_abort <= 1'b0;
    end
    else if (mode == 1)
    begin
      rd(BASE, SZW, d);
      chk(d, 32'h0);
    end
    wait_end(n);
    chk({running, halt_st}, 2'b01);
    chk(und, mode == 2);
    chk(acc_err, mode == 1);
    chk(n, mode != 0);
    chk({ptr1, ptr2}, {25'h041012A, 25'h0A20300});
  endtask

  initial
  begin
    err_count = 0;
    num_checks = 0;
    rst_b = 1'b0;
    list_start = 1'b0;
    list_start_addr = 16'h0;
    list_abort = 1'b0;
    halt_clr = 1'b0;
    flag_clr = 1'b0;
    round = 1'b1;
    acc_clr = 1'b0;
    mac = '0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    t_map();
    t_prog();
    t_load();
    t_la(1'b1);
    t_la(1'b0);
    @(posedge clk);
    round <= 1'b1;
    t_mac(DT_INT, 1'b0);
    for (int i = 0; i < 6; i++)
      t_mac(vsu_dtype_t'(i), 1'b1);
    t_mac(DT_REAL, 1'b0);
    t_stop(0, 16'h0030);
    t_stop(1, 16'h0030);
    t_stop(2, 16'h0028);
    test_done();
  end

  initial
  begin
    repeat (4000) @(posedge clk);
    err_count++;
    test_done();
  end
endmodule
`default_nettype wire

// >>> verification/vsu_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module vsu_host_model
  import vsu_pkg::*;
(
  // Clock
  input  wire logic          CLK,
  // Memory port toward the shared RAM
  output var vsu_host_req_t  HOST_REQ,
  input  wire logic [31:0]   HOST_RDATA
);
  initial HOST_REQ = '0;

  // One strobe cycle, then release with strobes low and address, size and data inverted
  task automatic access(input logic [31:0] a, input logic [1:0] sz,
                        input logic [31:0] wd, input logic we,
                        output logic [31:0] rdat);
    @(posedge CLK);
    HOST_REQ <= '{addr: a, size: sz, wdata: wd, wr: we, rd: ~we};
    @(posedge CLK);
    HOST_REQ <= '{addr: ~a, size: ~sz, wdata: ~wd, wr: 1'b0, rd: 1'b0};
    #1 rdat = HOST_RDATA;
  endtask
endmodule
`default_nettype wire
